//--- logic/ormp_top.sv
// Read-output pipeline of a dual-port block memory with APB option registers
`timescale 1ns/100ps
// How it works
// - Two register options per port, set separately
// - Primitive option enables each primitive register
// - Core option registers data after the mux
// - Both options register twice on the port
// - Primitive only: mux output stays unregistered
// - Core only: primitive registers are switched off
// - No option: data straight from read latches
// - Latch clearing only for prim-only with reset
// - Plain reset clears stage, never the latch
// - Latch clearing resets latch and primitive stage
// - Unsuitable dedicated reset: build stage from logic
// - Latch clearing forces dedicated primitive registers
// - Latch clearing: reset value shown two cycles
// - Logic-built stage reset gated by clock enable
module ormp_top
  import ormp_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [APB_AW-1:0] PADDR,
  input  wire logic [APB_DW-1:0] PWDATA,
  output logic      [APB_DW-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire ormp_req_s         PORT_A_REQ,
  input  wire ormp_req_s         PORT_B_REQ,
  output logic      [DATA_W-1:0] PORT_A_DOUT,
  output logic      [DATA_W-1:0] PORT_B_DOUT
);

  // Address decode shared by the read and the write path
  function automatic logic apb_hit(input logic [APB_AW-1:0] a);
    return (a == CFG_A_OFS) || (a == CFG_B_OFS) || (a == STAT_OFS);
  endfunction : apb_hit

  ormp_cfg_s         cfg_ff   [NPORT];
  ormp_mode_s        mode     [NPORT];
  ormp_req_s         req      [NPORT];
  logic [APB_DW-1:0] prdata_ff;
  logic [APB_DW-1:0] nxt_prdata;
  logic              pready_ff;
  logic              pslverr_ff;
  logic              apb_access;
  logic              apb_done;
  logic [APB_DW-1:0] stat_word;

  logic [NPORT-1:0]  prim_en  [NPRIM];
  logic [NPORT-1:0]  prim_we;
  logic [PRIM_AW-1:0] prim_addr [NPORT];
  logic [DATA_W-1:0] prim_wdata [NPORT];
  logic [NPORT-1:0]  read_latch_reset;
  logic [DATA_W-1:0] lat_data [NPRIM][NPORT];
  logic [DATA_W-1:0] stg_data [NPRIM][NPORT];
  logic [DATA_W-1:0] mux_data [NPORT];
  logic [DATA_W-1:0] dout     [NPORT];

  assign req[0] = PORT_A_REQ;
  assign req[1] = PORT_B_REQ;

  // APB: first access cycle prepares the answer, the pready edge commits it
  assign apb_access = PSEL && PENABLE && !pready_ff;
  assign apb_done   = PSEL && PENABLE && pready_ff;

  always_comb begin
    stat_word = RD_ZERO;
    for (int p = 0; p < NPORT; p++) begin
      stat_word[p*STAT_SHIFT +: STAT_FLD_W] = {cfg_ff[p].core_reg, cfg_ff[p].prim_reg,
                                               mode[p].latch_clr_act, mode[p].dedicated};
    end
  end

  always_comb begin
    nxt_prdata = RD_ZERO;
    unique case (PADDR)
      CFG_A_OFS: nxt_prdata[CFG_W-1:0] = cfg_ff[0];
      CFG_B_OFS: nxt_prdata[CFG_W-1:0] = cfg_ff[1];
      STAT_OFS:  nxt_prdata = stat_word;
      default:   nxt_prdata = RD_ZERO;
    endcase
  end

  // Handshake flops; pready stands exactly one cycle per transfer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= RD_ZERO;
    end else begin
      pready_ff <= apb_access;
      if (apb_access) begin
        pslverr_ff <= !apb_hit(PADDR);
        prdata_ff  <= PWRITE ? RD_ZERO : nxt_prdata;
      end else if (apb_done) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Option words, written only at the completing edge; each port independent
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_ff[0] <= CFG_RESET;
      cfg_ff[1] <= CFG_RESET;
    end else if (apb_done && PWRITE) begin
      if (PADDR == CFG_A_OFS) begin
        cfg_ff[0] <= PWDATA[CFG_W-1:0];
      end
      if (PADDR == CFG_B_OFS) begin
        cfg_ff[1] <= PWDATA[CFG_W-1:0];
      end
    end
  end

  assign PREADY  = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign PRDATA  = prdata_ff;

  // Memory primitives; the top address bit picks the primitive
  for (genvar i = 0; i < NPRIM; i++) begin : g_prim
    for (genvar p = 0; p < NPORT; p++) begin : g_en
      assign prim_en[i][p] = req[p].en && (req[p].addr[ADDR_W-1 -: SEL_W] == SEL_W'(i));
    end
    ormp_prim u_prim (
      .clk              (CLK),
      .arst_n           (ARST_N),
      .en               (prim_en[i]),
      .we               (prim_we),
      .addr             (prim_addr),
      .wdata            (prim_wdata),
      .read_latch_reset (read_latch_reset),
      .rdata            (lat_data[i])
    );
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [SEL_W-1:0] sel_lat_ff;
    logic [SEL_W-1:0] sel_stg_ff;
    logic [SEL_W-1:0] sel_mux;
    logic             output_register_reset;

    assign mode[p]       = ormp_eff_mode(cfg_ff[p]);
    assign prim_we[p]    = req[p].we;
    assign prim_addr[p]  = req[p].addr[PRIM_AW-1:0];
    assign prim_wdata[p] = req[p].wdata;

    // Latch is cleared only in the latch-clearing mode; plain reset leaves it alone
    assign read_latch_reset[p]  = req[p].sync_reset && mode[p].latch_clr_act;
    assign output_register_reset = req[p].sync_reset && cfg_ff[p].use_rst;

    // Primitive select follows the data so the mux never mixes two reads
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        sel_lat_ff <= '0;
      end else if (req[p].en) begin
        sel_lat_ff <= req[p].addr[ADDR_W-1 -: SEL_W];
      end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        sel_stg_ff <= '0;
      end else if (req[p].regce) begin
        sel_stg_ff <= sel_lat_ff;
      end
    end

    assign sel_mux = cfg_ff[p].prim_reg ? sel_stg_ff : sel_lat_ff;

    // One stage per primitive; both the dedicated and the logic-built form gate reset by CE
    for (genvar i = 0; i < NPRIM; i++) begin : g_pstg
      ormp_stage u_pstg (
        .clk                   (CLK),
        .arst_n                (ARST_N),
        .stage_on              (cfg_ff[p].prim_reg),
        .ce                    (req[p].regce),
        .output_register_reset (output_register_reset),
        .d                     (lat_data[i][p]),
        .q                     (stg_data[i][p])
      );
    end

    // Merge of primitives; left unregistered unless the core stage is on
    assign mux_data[p] = stg_data[sel_mux][p];

    ormp_stage u_cstg (
      .clk                   (CLK),
      .arst_n                (ARST_N),
      .stage_on              (cfg_ff[p].core_reg),
      .ce                    (req[p].regce),
      .output_register_reset (output_register_reset),
      .d                     (mux_data[p]),
      .q                     (dout[p])
    );

    // Checks on this port
    logic cfg_quiet;
    assign cfg_quiet = !(apb_done && PWRITE);

    sequence s_clear_hit;
      mode[p].latch_clr_act && req[p].sync_reset && req[p].en && req[p].regce && cfg_quiet;
    endsequence

    sequence s_idle_read;
      !req[p].en && req[p].regce && !req[p].sync_reset && cfg_quiet;
    endsequence

    a_latch_offer_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
      mode[p].latch_clr_act |-> cfg_ff[p].prim_reg && cfg_ff[p].use_rst && !cfg_ff[p].core_reg)
      else $error("latch clearing active outside prim-only reset mode");

    a_latch_force_ded: assert property (@(posedge CLK) disable iff (!ARST_N)
      mode[p].latch_clr_act |-> mode[p].dedicated)
      else $error("latch clearing without dedicated register");

    a_fabric_variant: assert property (@(posedge CLK) disable iff (!ARST_N)
      cfg_ff[p].prim_reg && cfg_ff[p].use_rst && !cfg_ff[p].ded_rst_ok && !mode[p].latch_clr_act
      |-> !mode[p].dedicated)
      else $error("dedicated register kept although its reset is unsuitable");

    a_latch_untouched: assert property (@(posedge CLK) disable iff (!ARST_N)
      req[p].sync_reset && !mode[p].latch_clr_act |-> !read_latch_reset[p])
      else $error("plain reset reached the read latch");

    a_latch_cleared: assert property (@(posedge CLK) disable iff (!ARST_N)
      read_latch_reset[p] && prim_en[0][p] |=> lat_data[0][p] == RD_RESET_VAL)
      else $error("read latch not cleared by port reset");

    a_reset_two_cyc: assert property (@(posedge CLK) disable iff (!ARST_N)
      s_clear_hit ##1 s_idle_read |-> dout[p] == RD_RESET_VAL ##1 dout[p] == RD_RESET_VAL)
      else $error("reset value not held for two cycles");

    a_core_one_cycle: assert property (@(posedge CLK) disable iff (!ARST_N)
      cfg_ff[p].core_reg && req[p].regce && !output_register_reset && cfg_quiet
      |=> dout[p] == $past(mux_data[p]))
      else $error("core stage did not add exactly one cycle");

    a_prim_comb_mux: assert property (@(posedge CLK) disable iff (!ARST_N)
      !cfg_ff[p].core_reg |-> dout[p] == mux_data[p])
      else $error("mux output registered without core stage");

    a_direct_latch: assert property (@(posedge CLK) disable iff (!ARST_N)
      !cfg_ff[p].prim_reg && !cfg_ff[p].core_reg |-> dout[p] == lat_data[sel_lat_ff][p])
      else $error("output not driven from read latch");

    a_fabric_ce_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
      cfg_ff[p].prim_reg && output_register_reset && !req[p].regce
      |=> $stable(stg_data[0][p]) || !cfg_ff[p].prim_reg)
      else $error("stage reset acted without clock enable");

    a_both_two_cyc: assert property (@(posedge CLK) disable iff (!ARST_N)
      cfg_ff[p].prim_reg && cfg_ff[p].core_reg && req[p].regce && !output_register_reset
      ##1 cfg_ff[p].prim_reg && cfg_ff[p].core_reg && req[p].regce && !output_register_reset && cfg_quiet
      |=> dout[p] == $past(lat_data[sel_lat_ff][p], 2))
      else $error("two stages did not add two cycles");
  end

  assign PORT_A_DOUT = dout[0];
  assign PORT_B_DOUT = dout[1];

endmodule : ormp_top

//--- common/ormp_pkg.sv
// Shared constants, types and mode decoding for the memory read-output pipeline
package ormp_pkg;

  // Memory shape: NPRIM primitives, each 2**PRIM_AW words, merged by the top address bit
  localparam int NPORT   = 2;
  localparam int NPRIM   = 2;
  localparam int PRIM_AW = 4;
  localparam int ADDR_W  = PRIM_AW + 1;
  localparam int DATA_W  = 8;
  localparam int SEL_W   = 1;

  // Value shown by a latch or stage register after a port reset
  localparam logic [DATA_W-1:0] RD_RESET_VAL = 8'h00;

  // APB register map, byte addresses
  localparam int              APB_AW     = 8;
  localparam int              APB_DW     = 32;
  localparam logic [APB_AW-1:0] CFG_A_OFS  = 8'h00;
  localparam logic [APB_AW-1:0] CFG_B_OFS  = 8'h04;
  localparam logic [APB_AW-1:0] STAT_OFS   = 8'h08;
  localparam int              STAT_FLD_W = 4;
  localparam int              STAT_SHIFT = 8;
  localparam logic [APB_DW-1:0] RD_ZERO    = 32'h0000_0000;

  // Per-port option word, bit 0 is prim_reg
  typedef struct packed {
    logic ded_rst_ok;   // Dedicated primitive register has a usable reset
    logic latch_clr;    // Port reset also clears the read latch
    logic use_rst;      // Port sync reset input is in use
    logic core_reg;     // Register after the primitive mux
    logic prim_reg;     // Register on each primitive output
  } ormp_cfg_s;

  localparam int          CFG_W     = $bits(ormp_cfg_s);
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // Resolved implementation of one port
  typedef struct packed {
    logic dedicated;      // Primitive stage uses the dedicated register
    logic latch_clr_act;  // Latch clearing really in force
  } ormp_mode_s;

  // One read or write request from user logic on a port
  typedef struct packed {
    logic              en;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              regce;       // Clock enable of the output stages
    logic              sync_reset;  // Port synchronous reset
  } ormp_req_s;

  // Latch clearing only counts for prim-only with reset; it then forces the dedicated register
  function automatic ormp_mode_s ormp_eff_mode(input ormp_cfg_s c);
    ormp_mode_s m;
    m.latch_clr_act = c.latch_clr & c.prim_reg & c.use_rst & ~c.core_reg;
    m.dedicated     = c.prim_reg & (m.latch_clr_act | ~c.use_rst | c.ded_rst_ok);
    return m;
  endfunction : ormp_eff_mode

endpackage : ormp_pkg

//--- logic/ormp_prim.sv
// One dual-port memory primitive with a registered read latch per port
`timescale 1ns/100ps
module ormp_prim
  import ormp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic [NPORT-1:0]    en,
  input  wire logic [NPORT-1:0]    we,
  input  wire logic [PRIM_AW-1:0]  addr [NPORT],
  input  wire logic [DATA_W-1:0]   wdata [NPORT],
  input  wire logic [NPORT-1:0]    read_latch_reset,
  output logic      [DATA_W-1:0]   rdata [NPORT]
);

  logic [DATA_W-1:0] mem [2**PRIM_AW];

  // Array writes; port B lands last when both ports hit one word
  always_ff @(posedge clk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (en[p] && we[p]) begin
        mem[addr[p]] <= wdata[p];
      end
    end
  end

  // Read latches, read-before-write; reset is gated by the port enable
  for (genvar p = 0; p < NPORT; p++) begin : g_latch
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        rdata[p] <= RD_RESET_VAL;
      end else if (en[p]) begin
        if (read_latch_reset[p]) begin
          rdata[p] <= RD_RESET_VAL;
        end else begin
          rdata[p] <= mem[addr[p]];
        end
      end
    end
  end

endmodule : ormp_prim

//--- logic/ormp_stage.sv
// Optional output register stage with bypass, clock enable and sync reset
`timescale 1ns/100ps
module ormp_stage
  import ormp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              stage_on,
  input  wire logic              ce,
  input  wire logic              output_register_reset,
  input  wire logic [DATA_W-1:0] d,
  output logic      [DATA_W-1:0] q
);

  logic [DATA_W-1:0] q_ff;

  // Reset only acts while the clock enable is high, like the primitive register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= RD_RESET_VAL;
    end else if (ce) begin
      if (output_register_reset) begin
        q_ff <= RD_RESET_VAL;
      end else begin
        q_ff <= d;
      end
    end
  end

  // Switched off, the stage is a wire and adds no cycle
  assign q = stage_on ? q_ff : d;

endmodule : ormp_stage

//--- tb/ormp_user.sv
// Behavioural user logic issuing reads and writes on one memory port
`timescale 1ns/100ps
module ormp_user
  import ormp_pkg::*;
(
  input  wire logic clk,
  output ormp_req_s req
);
  // Idle from time zero
  initial begin
    req = '0;
  end

  // One request per cycle, changed just after a rising edge
  task automatic drive(input logic en, input logic we, input logic [ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] wdata, input logic regce, input logic rst);
    @(posedge clk);
    req.en         <= en;
    req.we         <= we;
    // Unused fields are scrambled, so the block cannot lean on stale values
    req.addr       <= en ? addr : ~req.addr;
    req.wdata      <= (en && we) ? wdata : ~req.wdata;
    req.regce      <= regce;
    req.sync_reset <= rst;
  endtask : drive
endmodule : ormp_user

//--- tb/testbench.sv
// Self-checking bench for the read-output pipeline: APB options and port latencies
`timescale 1ns/100ps
module testbench
  import ormp_pkg::*;
;
  logic              clk;
  logic              arst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  ormp_req_s         req_a;
  ormp_req_s         req_b;
  logic [DATA_W-1:0] dout_a;
  logic [DATA_W-1:0] dout_b;
  logic [CFG_W-1:0]  cfg_a;
  logic [CFG_W-1:0]  cfg_b;
  logic [APB_DW-1:0] rd;
  logic              err;
  int                num_errors;
  int                n_tests;

  ormp_top ormp_top_i (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORT_A_REQ(req_a), .PORT_B_REQ(req_b), .PORT_A_DOUT(dout_a), .PORT_B_DOUT(dout_b)
  );
  ormp_user user_a (.clk(clk), .req(req_a));
  ormp_user user_b (.clk(clk), .req(req_b));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk_word(input string nm, input logic [APB_DW-1:0] exp, input logic [APB_DW-1:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word

  task automatic chk_byte(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_byte

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  // One APB transfer; the wait is bounded since the slave's answer time is not assumed
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] wd,
                     output logic [APB_DW-1:0] rdv, output logic errv);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end else begin
      rdv     = prdata;
      errv    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // Status nibble {core, prim, latch clearing in force, dedicated register}
  function automatic logic [3:0] stat_nib(input logic [CFG_W-1:0] c);
    logic la;
    la = c[3] & c[0] & c[2] & ~c[1];
    return {c[1], c[0], la, c[0] & (la | ~c[2] | c[4])};
  endfunction : stat_nib

  // Writes a port option word, reads it back and checks the status word
  task automatic set_cfg(input int p, input logic [CFG_W-1:0] c);
    apb(1'b1, p ? CFG_B_OFS : CFG_A_OFS, APB_DW'(c), rd, err);
    chk_bit("PSLVERR", 1'b0, err);
    if (p == 0) cfg_a = c;
    else cfg_b = c;
    apb(1'b0, p ? CFG_B_OFS : CFG_A_OFS, 32'h0, rd, err);
    chk_word("CFG", APB_DW'(c), rd);
    apb(1'b0, STAT_OFS, 32'h0, rd, err);
    chk_word("STAT", {20'h0, stat_nib(cfg_b), 4'h0, stat_nib(cfg_a)}, rd);
  endtask : set_cfg

  task automatic drv(input int p, input logic en, input logic we, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic ce, input logic rst);
    if (p == 0) user_a.drive(en, we, a, d, ce, rst);
    else user_b.drive(en, we, a, d, ce, rst);
  endtask : drv

  // Idle cycle with clock enable high, then a look at the port output
  task automatic idle_chk(input int p, input logic [DATA_W-1:0] exp);
    drv(p, 1'b0, 1'b0, 5'h00, 8'h00, 1'b1, 1'b0);
    @(negedge clk);
    chk_byte(p ? "PORT_B_DOUT" : "PORT_A_DOUT", exp, p ? dout_b : dout_a);
  endtask : idle_chk

  // Read, then the old value until the latency is reached and the new one exactly then
  task automatic rd_lat(input int p, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] old_v,
                        input logic [DATA_W-1:0] new_v, input int lat);
    drv(p, 1'b1, 1'b0, a, 8'h00, 1'b1, 1'b0);
    for (int i = 1; i <= lat; i++) begin
      idle_chk(p, (i < lat) ? old_v : new_v);
    end
  endtask : rd_lat

  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; cfg_a = '0; cfg_b = '0;
    num_errors = 0; n_tests = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, unmapped access and a write to the read-only status word
    apb(1'b0, CFG_A_OFS, 32'h0, rd, err); chk_word("CFG_A", RD_ZERO, rd);
    apb(1'b0, CFG_B_OFS, 32'h0, rd, err); chk_word("CFG_B", RD_ZERO, rd);
    apb(1'b0, 8'h0c, 32'h0, rd, err); chk_bit("PSLVERR", 1'b1, err);
    apb(1'b1, STAT_OFS, 32'hffff_ffff, rd, err); chk_bit("PSLVERR", 1'b0, err);
    set_cfg(0, 5'h00);
    // Fill two words of one primitive; a same-word clash leaves port B's data
    drv(0, 1'b1, 1'b1, 5'h12, 8'h5a, 1'b1, 1'b0);
    drv(0, 1'b1, 1'b1, 5'h13, 8'hc3, 1'b1, 1'b0);
    fork
      user_a.drive(1'b1, 1'b1, 5'h05, 8'h11, 1'b1, 1'b0);
      user_b.drive(1'b1, 1'b1, 5'h05, 8'h22, 1'b1, 1'b0);
    join
    rd_lat(0, 5'h05, 8'hxx, 8'h22, 1);
    // Every stage combination on both ports; port A keeps its last options while B varies
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        set_cfg(p, CFG_W'(c));
        // Every stage keeps following its input while idle, so the port still shows the last word read
        rd_lat(p, 5'h12, 8'hc3, 8'h5a, 1 + c % 2 + c / 2);
        rd_lat(p, 5'h13, 8'h5a, 8'hc3, 1 + c % 2 + c / 2);
      end
    end
    // Plain port reset on a logic-built primitive stage
    set_cfg(0, 5'h05);
    rd_lat(0, 5'h13, 8'hc3, 8'hc3, 2);
    drv(0, 1'b0, 1'b0, 5'h00, 8'h00, 1'b0, 1'b1);
    drv(0, 1'b0, 1'b0, 5'h00, 8'h00, 1'b0, 1'b0);
    @(negedge clk);
    chk_byte("PORT_A_DOUT", 8'hc3, dout_a);
    drv(0, 1'b0, 1'b0, 5'h00, 8'h00, 1'b1, 1'b1);
    idle_chk(0, RD_RESET_VAL);
    idle_chk(0, 8'hc3);
    // Latch-clearing reset: the reset value stands three idle cycles and the latch stays clear
    set_cfg(0, 5'h0d);
    rd_lat(0, 5'h13, 8'hc3, 8'hc3, 2);
    drv(0, 1'b1, 1'b0, 5'h13, 8'h00, 1'b1, 1'b1);
    idle_chk(0, RD_RESET_VAL);
    idle_chk(0, RD_RESET_VAL);
    idle_chk(0, RD_RESET_VAL);
    rd_lat(0, 5'h13, RD_RESET_VAL, 8'hc3, 2);
    // Latch clearing with the core stage, and a dedicated register with a usable reset
    set_cfg(0, 5'h0f);
    set_cfg(0, 5'h15);
    conclude();
  end
endmodule : testbench
